/* File: rtl/ebk_consts.svh */
`ifndef EBK_CONSTS_SVH
`define EBK_CONSTS_SVH

// Register indices; byte address is four times the index
`define EBK_CTRL_IDX        8'h29
`define EBK_STAT_IDX        8'h2A
`define EBK_IDX_LSB         2

// Control register field positions
`define EBK_BACK_TO_BACK_SWITCH_BIT      15
`define EBK_DIV_HI          14
`define EBK_DIV_LO          13
`define EBK_SUPP_BIT        12
`define EBK_HBH_BIT         2
`define EBK_BH_BIT          1

// Control register reset values
`define EBK_BACK_TO_BACK_SWITCH_RST      1'h0
`define EBK_DIV_RST         2'h3
`define EBK_SUPP_RST        1'h1
`define EBK_HBH_RST         1'h0
`define EBK_BH_RST          1'h0

// Status register field positions
`define EBK_STAT_MSB_BIT    0
`define EBK_STAT_BUSY_BIT   1

// Bank boundary: address bit that selects the 32K-word bank
`define EBK_BANK_BIT        15
`define EBK_PAGE_LSB        16

`endif

/* File: rtl/ebk_pkg.sv */
package ebk_pkg;

	typedef enum logic [1:0] {
		EBK_SP_PROG,
		EBK_SP_DATA,
		EBK_SP_IO
	} ebk_space_e;

	typedef enum {
		EBK_IDLE,
		EBK_LEAD,
		EBK_ACCESS,
		EBK_TRAIL,
		EBK_DONE
	} ebk_state_e;

	typedef struct packed {
		logic       back_to_back_switch;
		logic [1:0] clk_pin_divider;
		logic       ack_output_suppress;
		logic       host_data_keeper_en;
		logic       ext_data_keeper_en;
	} ebk_ctrl_s;

	typedef struct packed {
		ebk_space_e  space;
		logic        write;
		logic [22:0] addr;
		logic [15:0] wdata;
	} ebk_req_s;

endpackage

/* File: rtl/ebk_bank_switch.sv */
`include "ebk_consts.svh"

// What this block does
// - With the back-to-back bit clear, only reads that change bank, or space or program page after a read, get a lead cycle; none gets a trail cycle.
// - With the back-to-back bit set, each external memory read runs as a lead cycle, the read cycle and a trail cycle.
// - The clock pin runs at the core clock divided by divider field plus one, and the field resets to divide-by-4.
// - The suppress bit resets to one and while set keeps the interrupt acknowledge output inactive.
// - The host data keeper bit resets to zero and when set holds the idle host data bus; when clear the keeper is off unless wide host mode is selected.
// - The external data keeper bit resets to zero and when set holds the idle 16-bit external data bus.
// - A register keeps the top address bit of the last program or data access of either direction.
// - In non back-to-back mode a read whose top bit differs from the stored one stores it, then keeps the strobe off one pin cycle while the address moves.
// - In non back-to-back mode a read whose top bit matches the stored one runs with no extra cycle unless it follows a read of another space or program page.
// - One extra cycle is added for read then read of another bank, program read then data read, data read then program read, and program read then program read of another page.
// - The data keeper follows the data keeper bit, the host keeper is on when wide mode or the host bit is set, and the address keeper only when both are.
// - A 64K-port I/O space is reached by port read and write requests, and the I/O strobe is asserted during each of them.
// - The control register sits at register index 29h and is read and written by software.
module ebk_bank_switch
	import ebk_pkg::*;
#(
	parameter int ADDR_W = 23,
	parameter int IO_W   = 16
) (
	input  wire logic              clk_i,           // Core clock
	input  wire logic              rst_i,           // Sync reset, high
	input  wire logic              ce_i,            // Clock enable
	input  wire logic [31:0]       wb_adr_i,        // Wishbone address
	input  wire logic [31:0]       wb_dat_i,        // Wishbone write data
	output logic      [31:0]       wb_dat_o,        // Wishbone read data
	input  wire logic              wb_we_i,         // Wishbone write
	input  wire logic [3:0]        wb_sel_i,        // Wishbone byte lanes
	input  wire logic              wb_cyc_i,        // Wishbone cycle
	input  wire logic              wb_stb_i,        // Wishbone strobe
	output logic                   wb_ack_o,        // Wishbone ack
	input  wire logic              req_valid_i,     // Core access request
	output logic                   req_ready_o,     // Request taken
	input  wire ebk_req_s          req_i,           // Access descriptor
	output logic                   done_o,          // Access finished
	output logic      [15:0]       rdata_o,         // Read data to core
	output logic      [ADDR_W-1:0] mem_addr_o,      // External address
	output logic      [15:0]       mem_wdata_o,     // External write data
	output logic                   mem_wdata_oe_o,  // Drive data bus
	input  wire logic [15:0]       mem_rdata_i,     // External read data
	output logic                   mem_rd_o,        // Read direction
	output logic                   memory_strobe_n_o,  // Prog/data strobe
	output logic                   io_space_strobe_n_o, // I/O strobe
	output logic                   clock_out_pin_o, // Divided clock pin
	input  wire logic              irq_ack_i,       // Core acknowledge
	output logic                   interrupt_ack_out_n_o, // Ack pin
	input  wire logic              wide_host_select_i, // Wide host strap
	output logic                   ext_data_keeper_o,  // D bus keeper
	output logic                   addr_keeper_o,   // A bus keeper
	output logic                   host_data_keeper_o  // HD bus keeper
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [15:0] ctrl_pack(input ebk_ctrl_s c);
		logic [15:0] w;
		w = 16'h0000;
		w[`EBK_BACK_TO_BACK_SWITCH_BIT]          = c.back_to_back_switch;
		w[`EBK_DIV_HI:`EBK_DIV_LO]  = c.clk_pin_divider;
		w[`EBK_SUPP_BIT]            = c.ack_output_suppress;
		w[`EBK_HBH_BIT]             = c.host_data_keeper_en;
		w[`EBK_BH_BIT]              = c.ext_data_keeper_en;
		return w;
	endfunction

	// Byte lanes merge into the old value; unlisted bits stay zero
	function automatic ebk_ctrl_s ctrl_write(input ebk_ctrl_s c,
		input logic [15:0] d, input logic [1:0] sel);
		logic [15:0] w;
		ebk_ctrl_s   n;
		w = ctrl_pack(c);
		if (sel[0])
			w[7:0] = d[7:0];
		if (sel[1])
			w[15:8] = d[15:8];
		n.back_to_back_switch = w[`EBK_BACK_TO_BACK_SWITCH_BIT];
		n.clk_pin_divider     = w[`EBK_DIV_HI:`EBK_DIV_LO];
		n.ack_output_suppress = w[`EBK_SUPP_BIT];
		n.host_data_keeper_en = w[`EBK_HBH_BIT];
		n.ext_data_keeper_en  = w[`EBK_BH_BIT];
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register bus

	localparam ebk_ctrl_s CTRL_RST = '{
		back_to_back_switch: `EBK_BACK_TO_BACK_SWITCH_RST,
		clk_pin_divider:     `EBK_DIV_RST,
		ack_output_suppress: `EBK_SUPP_RST,
		host_data_keeper_en: `EBK_HBH_RST,
		ext_data_keeper_en:  `EBK_BH_RST
	};

	ebk_ctrl_s   ctrl_reg;
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic        last_msb_reg;
	ebk_state_e  state_reg;

	wire logic [7:0]  bus_idx   = wb_adr_i[`EBK_IDX_LSB +: 8];
	wire logic        bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
	wire logic        hit_ctrl  = bus_idx == `EBK_CTRL_IDX;
	wire logic        hit_stat  = bus_idx == `EBK_STAT_IDX;
	// Write lands on the edge where the master sees ack, while its
	// request still stands, so a dropped cycle never half-commits
	wire logic        ctrl_wr   = wb_cyc_i && wb_stb_i && ack_reg &&
		wb_we_i && hit_ctrl;
	wire logic [15:0] stat_word = {14'h0000, state_reg != EBK_IDLE,
		last_msb_reg};
	wire logic [31:0] rd_mux    = hit_ctrl ? {16'h0000, ctrl_pack(ctrl_reg)}
		: hit_stat ? {16'h0000, stat_word} : 32'h0000_0000;

	// Unmapped addresses are acked with zero data so the bus never hangs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RST;
		end else if (ce_i) begin
			ack_reg  <= bus_req;
			if (bus_req && !wb_we_i)
				rdat_reg <= rd_mux;
			if (ctrl_wr)
				ctrl_reg <= ctrl_write(ctrl_reg, wb_dat_i[15:0],
					wb_sel_i[1:0]);
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	////////////////////////////////////////////////////////////////////////
	// Clock pin divider

	logic [1:0] div_cnt_reg;
	logic       clk_pin_reg;

	wire logic [1:0] div_lim  = ctrl_reg.clk_pin_divider;
	wire logic       div_wrap = div_cnt_reg >= div_lim;
	wire logic       tick     = ce_i && div_wrap;
	wire logic [1:0] div_next = div_wrap ? 2'h0 : div_cnt_reg + 2'h1;
	// High for the first half of each period, rounded up
	wire logic       pin_next = {1'b0, div_next} < ({1'b0, div_lim} +
		3'h2) >> 1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 2'h0;
			clk_pin_reg <= 1'b0;
		end else if (ce_i) begin
			div_cnt_reg <= div_next;
			clk_pin_reg <= pin_next;
		end
	end

	// Divide-by-one cannot come from a flop, so the core clock passes
	// straight through; the pin then carries a clock, not a data signal
	assign clock_out_pin_o = (div_lim == 2'h0) ? clk_i : clk_pin_reg;

	////////////////////////////////////////////////////////////////////////
	// Access sequencer

	ebk_req_s    cur_reg;
	logic        last_rd_reg;
	ebk_space_e  last_sp_reg;
	logic [ADDR_W-`EBK_PAGE_LSB-1:0] last_page_reg;
	logic [15:0] rdata_reg;
	logic        done_reg;
	ebk_state_e  state_next;

	wire logic       take     = req_valid_i && req_ready_o && ce_i;
	wire logic       new_rd   = !req_i.write;
	wire logic       new_mem  = req_i.space != EBK_SP_IO;
	wire logic       new_msb  = req_i.addr[`EBK_BANK_BIT];
	wire logic [ADDR_W-`EBK_PAGE_LSB-1:0] new_page =
		req_i.addr[ADDR_W-1:`EBK_PAGE_LSB];
	wire logic       bank_chg = new_msb != last_msb_reg;
	wire logic       sp_chg   = last_rd_reg && req_i.space != last_sp_reg;
	wire logic       page_chg = last_rd_reg && last_sp_reg == EBK_SP_PROG &&
		req_i.space == EBK_SP_PROG && new_page != last_page_reg;
	// Gap only for memory reads; writes and port accesses never need it
	wire logic       need_gap = new_mem && new_rd &&
		(ctrl_reg.back_to_back_switch || bank_chg || sp_chg ||
		page_chg);
	wire logic       cur_rd   = !cur_reg.write;
	wire logic       cur_mem  = cur_reg.space != EBK_SP_IO;
	wire logic       need_trl = cur_rd && cur_mem &&
		ctrl_reg.back_to_back_switch;

	assign req_ready_o = state_reg == EBK_IDLE;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			EBK_IDLE:
				if (take)
					state_next = need_gap ? EBK_LEAD : EBK_ACCESS;
			EBK_LEAD:
				if (tick)
					state_next = EBK_ACCESS;
			EBK_ACCESS:
				if (tick)
					state_next = need_trl ? EBK_TRAIL : EBK_DONE;
			EBK_TRAIL:
				if (tick)
					state_next = EBK_DONE;
			EBK_DONE:
				state_next = EBK_IDLE;
			default:
				state_next = EBK_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg     <= EBK_IDLE;
			cur_reg       <= '0;
			last_msb_reg  <= 1'b0;
			last_rd_reg   <= 1'b0;
			last_sp_reg   <= EBK_SP_PROG;
			last_page_reg <= '0;
			rdata_reg     <= 16'h0000;
			done_reg      <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			done_reg  <= state_reg == EBK_ACCESS && tick && !need_trl ||
				state_reg == EBK_TRAIL && tick;
			if (take) begin
				cur_reg <= req_i;
				if (new_mem) begin
					last_msb_reg  <= new_msb;
					last_rd_reg   <= new_rd;
					last_sp_reg   <= req_i.space;
					last_page_reg <= new_page;
				end
			end
			if (state_reg == EBK_ACCESS && tick && cur_rd)
				rdata_reg <= mem_rdata_i;
		end
	end

	wire logic in_acc = state_reg == EBK_ACCESS;

	assign done_o              = done_reg;
	assign rdata_o             = rdata_reg;
	assign mem_addr_o          = cur_reg.addr;
	assign mem_wdata_o         = cur_reg.wdata;
	assign mem_wdata_oe_o      = in_acc && !cur_rd;
	assign mem_rd_o            = cur_rd;
	assign memory_strobe_n_o   = !(in_acc && cur_mem);
	assign io_space_strobe_n_o = !(in_acc && !cur_mem);

	////////////////////////////////////////////////////////////////////////
	// Acknowledge gate and bus keepers

	logic ack_n_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_n_reg <= 1'b1;
		else if (ce_i)
			ack_n_reg <= !(irq_ack_i && !ctrl_reg.ack_output_suppress);
	end

	assign interrupt_ack_out_n_o = ack_n_reg;
	// Wide host strap is trusted to be tied correctly by the board
	assign ext_data_keeper_o  = ctrl_reg.ext_data_keeper_en;
	assign host_data_keeper_o = wide_host_select_i ||
		ctrl_reg.host_data_keeper_en;
	assign addr_keeper_o      = wide_host_select_i &&
		ctrl_reg.host_data_keeper_en;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ctrl_reset_a: assert property (
		$fell(rst_i) |-> ctrl_pack(ctrl_reg) == 16'h7000)
		else $error("control register reset value wrong");

	reserved_zero_a: assert property (
		wb_ack_o && $past(hit_ctrl) && !$past(wb_we_i) |->
		(wb_dat_o & 32'hFFFF_0FF9) == 32'h0000_0000)
		else $error("reserved control bits not zero");

	bus_ack_a: assert property (
		ce_i && bus_req ##1 ce_i |-> wb_ack_o ##1 !wb_ack_o)
		else $error("wishbone ack not a single cycle");

	div_bound_a: assert property (
		ce_i && $stable(div_lim) && div_cnt_reg == div_lim |=>
		div_cnt_reg == 2'h0)
		else $error("divider did not wrap at its limit");

	ack_gate_a: assert property (
		ce_i && ctrl_reg.ack_output_suppress |=> interrupt_ack_out_n_o)
		else $error("acknowledge output not suppressed");

	gap_insert_a: assert property (
		take && new_mem && new_rd && bank_chg |=>
		state_reg == EBK_LEAD && memory_strobe_n_o)
		else $error("bank change read missed its gap");

	no_gap_a: assert property (
		take && new_rd && new_mem && !need_gap |=> !memory_strobe_n_o)
		else $error("same bank read got an extra cycle");

	trail_cycle_a: assert property (
		in_acc && tick && need_trl |=> state_reg == EBK_TRAIL)
		else $error("back-to-back read lacks trail cycle");

	msb_track_a: assert property (
		take && new_mem |=> last_msb_reg == $past(new_msb))
		else $error("last address bit not captured");

	io_strobe_a: assert property (
		!io_space_strobe_n_o |-> in_acc && !cur_mem && memory_strobe_n_o)
		else $error("I/O strobe outside a port access");

	keeper_map_a: assert property (
		addr_keeper_o |-> host_data_keeper_o && wide_host_select_i)
		else $error("address keeper on without host keeper");

	lead_strobe_a: assert property (
		state_reg == EBK_LEAD |-> memory_strobe_n_o && io_space_strobe_n_o)
		else $error("strobe active during bank gap");

	lead_length_a: assert property (
		state_reg == EBK_LEAD && tick |=> in_acc)
		else $error("bank gap longer than one pin cycle");

	trail_strobe_a: assert property (
		state_reg == EBK_TRAIL |-> memory_strobe_n_o)
		else $error("strobe active during trail cycle");

	write_no_gap_a: assert property (
		take && req_i.write |=> in_acc)
		else $error("write got a bank gap");

	done_pulse_a: assert property (
		ce_i && done_o |=> !done_o)
		else $error("done held longer than one cycle");

endmodule

/* File: dv/ebk_mem_model.sv */
////////////////////////////////////////////////////////////////////////
module ebk_mem_model (
	input  wire logic        clk_i,         // Core clock
	input  wire logic [22:0] addr_i,        // External address
	input  wire logic        mem_strobe_n_i, // Memory strobe
	input  wire logic        io_strobe_n_i, // I/O strobe
	input  wire logic        rd_i,          // Read direction
	output logic      [15:0] rdata_o        // Data toward the block
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] last_q = 16'h0000;
	wire         sel_w = rd_i && !(mem_strobe_n_i && io_strobe_n_i);

	// Released bus shows the inverted last word, so a stale sample fails
	assign rdata_o = sel_w ? (addr_i[15:0] ^ 16'h5A3C) : ~last_q;

	always_ff @(posedge clk_i) begin
		if (sel_w) begin
			last_q <= rdata_o;
		end
	end
endmodule

/* File: dv/ebk_bank_switch_tb.sv */
`define EBK_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("unexpected at %0t: got %h exp %h", \
	$time, g, e); end end

////////////////////////////////////////////////////////////////////////
module ebk_bank_switch_tb
	import ebk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {ebk_req_s r; logic [2:0] lat;} ebk_note_s;

	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic [31:0] wb_adr_i = 32'h0000_0000, wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        req_valid_i = 1'b0, irq_ack_i = 1'b0;
	logic        wide_host_select_i = 1'b0;
	ebk_req_s    req_i = '0;
	logic        wb_ack_o, req_ready_o, done_o, mem_wdata_oe_o, mem_rd_o;
	logic [15:0] rdata_o, mem_wdata_o, mem_rdata_i;
	logic [22:0] mem_addr_o;
	logic        memory_strobe_n_o, io_space_strobe_n_o, clock_out_pin_o;
	logic        interrupt_ack_out_n_o, ext_data_keeper_o;
	logic        addr_keeper_o, host_data_keeper_o;
	int          err_total = 0, total_checks = 0, cnt = 0;
	logic        busy = 1'b0;
	ebk_note_s   acc_q[$], cur;
	logic [31:0] wb_q[$];

	always #2 clk_i = ~clk_i;

	ebk_bank_switch u_dut (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i,
		.wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
		.req_valid_i, .req_ready_o, .req_i, .done_o, .rdata_o, .mem_addr_o,
		.mem_wdata_o, .mem_wdata_oe_o, .mem_rdata_i, .mem_rd_o,
		.memory_strobe_n_o, .io_space_strobe_n_o, .clock_out_pin_o,
		.irq_ack_i, .interrupt_ack_out_n_o, .wide_host_select_i,
		.ext_data_keeper_o, .addr_keeper_o, .host_data_keeper_o);

	ebk_mem_model u_mem (.clk_i, .addr_i(mem_addr_o),
		.mem_strobe_n_i(memory_strobe_n_o),
		.io_strobe_n_i(io_space_strobe_n_o), .rd_i(mem_rd_o),
		.rdata_o(mem_rdata_i));

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] idx,
			input logic [15:0] d, input logic [15:0] exp);
		int n;
		if (!we) begin
			wb_q.push_back({16'h0000, exp});
		end
		wb_adr_i <= {22'h000000, idx, 2'h0};
		wb_dat_i <= {16'hFFFF, d};
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		for (n = 0; n < 40 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic acc(input ebk_space_e sp, input logic wr,
			input logic [22:0] a, input logic [2:0] lat);
		int n;
		ebk_note_s nt;
		nt = '{'{sp, wr, a, 16'($urandom)}, lat};
		acc_q.push_back(nt);
		req_i <= nt.r;
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		for (n = 0; n < 20 && req_ready_o !== 1'b1; n++) @(posedge clk_i);
		req_valid_i <= 1'b0;
		for (n = 0; n < 40 && done_o !== 1'b1; n++) @(posedge clk_i);
		if (done_o !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask

	// Outputs are read at the edge, before the block's own updates land
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) begin
			`EBK_CHK(wb_dat_o, wb_q.pop_front())
		end
		if (busy) begin
			cnt++;
		end
		if (busy && !(memory_strobe_n_o && io_space_strobe_n_o)) begin
			`EBK_CHK({memory_strobe_n_o, io_space_strobe_n_o},
				(cur.r.space == EBK_SP_IO) ? 2'b10 : 2'b01)
			`EBK_CHK(mem_addr_o, cur.r.addr)
			`EBK_CHK({mem_rd_o, mem_wdata_oe_o},
				{!cur.r.write, cur.r.write})
			if (cur.r.write) begin
				`EBK_CHK(mem_wdata_o, cur.r.wdata)
			end
		end else if (!rst_i && !busy) begin
			`EBK_CHK({memory_strobe_n_o, io_space_strobe_n_o}, 2'b11)
		end
		if (busy && done_o === 1'b1) begin
			`EBK_CHK(cnt, int'(cur.lat))
			if (!cur.r.write) begin
				`EBK_CHK(rdata_o, cur.r.addr[15:0] ^ 16'h5A3C)
			end
			busy = 1'b0;
		end
		if (req_valid_i && req_ready_o === 1'b1) begin
			cur = acc_q.pop_front();
			busy = 1'b1;
			cnt = 0;
		end
	end

	initial begin
		int k, d, rises;
		logic prev;
		void'($urandom(8));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 8'h29, 16'h0000, 16'h7000);
		wb(1'b1, 8'h29, 16'hFFFF, 16'h0000);
		wb(1'b0, 8'h29, 16'h0000, 16'hF006);
		wb(1'b0, 8'h40, 16'h0000, 16'h0000);
		irq_ack_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		`EBK_CHK(interrupt_ack_out_n_o, 1'b1)
		wb(1'b1, 8'h29, 16'h0000, 16'h0000);
		repeat (2) @(posedge clk_i);
		`EBK_CHK(interrupt_ack_out_n_o, 1'b0)
		irq_ack_i <= 1'b0;
		for (d = 3; d > 0; d--) begin
			wb(1'b1, 8'h29, {1'b0, 2'(d), 13'h0000}, 16'h0000);
			repeat (4) @(posedge clk_i);
			prev = clock_out_pin_o;
			rises = 0;
			repeat (24) begin
				@(posedge clk_i);
				rises += int'(clock_out_pin_o && !prev);
				prev = clock_out_pin_o;
			end
			`EBK_CHK(rises, 24 / (d + 1))
		end
		// Clock enable low must freeze the pin divider
		ce_i <= 1'b0;
		@(posedge clk_i);
		prev = clock_out_pin_o;
		repeat (3) @(posedge clk_i);
		`EBK_CHK(clock_out_pin_o, prev)
		ce_i <= 1'b1;
		wb(1'b1, 8'h29, 16'h0000, 16'h0000);
		#1;
		`EBK_CHK(clock_out_pin_o, 1'b1)
		#2;
		`EBK_CHK(clock_out_pin_o, 1'b0)
		@(posedge clk_i);
		for (k = 0; k < 8; k++) begin
			wide_host_select_i <= k[2];
			wb(1'b1, 8'h29, {13'h0000, k[0], k[1], 1'b0}, 16'h0000);
			`EBK_CHK(ext_data_keeper_o, k[1])
			`EBK_CHK(host_data_keeper_o, k[2] | k[0])
			`EBK_CHK(addr_keeper_o, k[2] & k[0])
		end
		wide_host_select_i <= 1'b0;
		acc(EBK_SP_PROG, 1'b1, 23'h000000, 3'h2);
		acc(EBK_SP_PROG, 1'b0, 23'h000010, 3'h2);
		acc(EBK_SP_PROG, 1'b0, 23'h000020, 3'h2);
		acc(EBK_SP_PROG, 1'b0, 23'h008000, 3'h3);
		acc(EBK_SP_DATA, 1'b0, 23'h008004, 3'h3);
		acc(EBK_SP_DATA, 1'b0, 23'h008008, 3'h2);
		acc(EBK_SP_PROG, 1'b0, 23'h008010, 3'h3);
		acc(EBK_SP_PROG, 1'b0, 23'h018010, 3'h3);
		wb(1'b0, 8'h2A, 16'h0000, 16'h0001);
		acc(EBK_SP_DATA, 1'b1, 23'h000000, 3'h2);
		wb(1'b0, 8'h2A, 16'h0000, 16'h0000);
		acc(EBK_SP_DATA, 1'b0, 23'h000004, 3'h2);
		acc(EBK_SP_IO, 1'b0, 23'h001234, 3'h2);
		acc(EBK_SP_IO, 1'b1, 23'h00FFFF, 3'h2);
		repeat (8) begin
			acc(EBK_SP_DATA, 1'($urandom), {8'h00, 15'($urandom)}, 3'h2);
		end
		wb(1'b1, 8'h29, 16'h8000, 16'h0000);
		acc(EBK_SP_PROG, 1'b0, 23'h000100, 3'h4);
		acc(EBK_SP_PROG, 1'b0, 23'h000102, 3'h4);
		acc(EBK_SP_DATA, 1'b1, 23'h000200, 3'h2);
		end_of_test();
	end
endmodule
